// ==== sys_cfg_pkg.sv ====
package sys_cfg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;
    localparam int NUM_INIT = 3;
    localparam int NUM_GATE = 3;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_UNLOCK = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;

    // configuration control field positions
    localparam int BIT_DMA_PRI  = 25;
    localparam int BIT_CPU_PRI  = 24;
    localparam int BIT_ICA      = 17;
    localparam int BIT_OCA      = 16;
    localparam int BIT_PPS_LOCK = 13;
    localparam int BIT_PMD_LOCK = 12;
    localparam int BIT_PG_LOCK  = 11;
    localparam int BIT_USB_SSEN = 8;

    localparam logic [DATA_W-1:0] CONFIG_IMPL  = 32'h0303_3900;
    localparam logic [DATA_W-1:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ZERO_WORD    = 32'h0000_0000;

    // unlock keys, written in this order to the unlock register
    localparam logic [DATA_W-1:0] UNLOCK_KEY1 = 32'hAA99_6655;
    localparam logic [DATA_W-1:0] UNLOCK_KEY2 = 32'h5566_99AA;

    // status field positions
    localparam int ST_UNLOCKED = 0;
    localparam int ST_LOCK_WR  = 1;
    localparam int ST_GATE_LO  = 4;
    localparam logic [DATA_W-1:0] STATUS_W1C = 32'h0000_0072;

    // write gate indices
    localparam int GATE_PPS = 0;
    localparam int GATE_PMD = 1;
    localparam int GATE_PG  = 2;

    // sram initiator indices
    localparam int INIT_DMA   = 0;
    localparam int INIT_CPU   = 1;
    localparam int INIT_OTHER = 2;

    typedef enum logic [1:0] {
        UNL_LOCKED = 2'b00,
        UNL_KEY1   = 2'b01,
        UNL_OPEN   = 2'b11
    } unlock_state_t;

endpackage

// ==== sys_cfg_if.sv ====
`timescale 1ns/1ns
interface sys_cfg_if;
    logic                                key_wr;
    logic [sys_cfg_pkg::DATA_W-1:0]      key_data;
    logic                                unlocked;
    logic                                dma_pri;
    logic                                cpu_pri;
    logic                                in_isr;
    logic [sys_cfg_pkg::NUM_INIT-1:0]    req;
    logic [sys_cfg_pkg::NUM_INIT-1:0]    grant;

    modport hub (
        output key_wr, key_data, dma_pri, cpu_pri, in_isr, req,
        input  unlocked, grant
    );
    modport unlock (
        input  key_wr, key_data,
        output unlocked
    );
    modport arb (
        input  dma_pri, cpu_pri, in_isr, req,
        output grant
    );
endinterface

// ==== sys_cfg_unlock.sv ====
`timescale 1ns/1ns
module sys_cfg_unlock (
    input  wire logic   i_clk,
    input  wire logic   i_rst,
    sys_cfg_if.unlock   bus
);
    import sys_cfg_pkg::*;

    unlock_state_t state_q;
    unlock_state_t state_d;
    logic          unlocked_q;

    // two keys back to back open the protected bits; anything else locks
    always_comb begin
        state_d = state_q;
        if (bus.key_wr) begin
            unique case (state_q)
                UNL_LOCKED: begin
                    state_d = (bus.key_data == UNLOCK_KEY1) ? UNL_KEY1
                                                            : UNL_LOCKED;
                end
                UNL_KEY1: begin
                    state_d = (bus.key_data == UNLOCK_KEY2) ? UNL_OPEN
                                                            : UNL_LOCKED;
                end
                UNL_OPEN: begin
                    state_d = (bus.key_data == UNLOCK_KEY1) ? UNL_KEY1
                                                            : UNL_LOCKED;
                end
                default: begin
                    state_d = UNL_LOCKED;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q    <= UNL_LOCKED;
            unlocked_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            unlocked_q <= (state_d == UNL_OPEN);
        end
    end

    assign bus.unlocked = unlocked_q;
endmodule

// ==== sram_prio_arbiter.sv ====
`timescale 1ns/1ns
module sram_prio_arbiter (
    input  wire logic   i_clk,
    input  wire logic   i_rst,
    sys_cfg_if.arb      bus
);
    import sys_cfg_pkg::*;

    logic [NUM_INIT-1:0] grant_q;
    logic [NUM_INIT-1:0] grant_d;
    logic [NUM_INIT-1:0] last_q;
    logic [NUM_INIT-1:0] rr_pick;
    logic                dma_high;
    logic                cpu_high;

    // least recently serviced: search starts after the last winner
    function automatic logic [NUM_INIT-1:0] pick_lrs(
        input logic [NUM_INIT-1:0] req,
        input logic [NUM_INIT-1:0] last
    );
        logic [2*NUM_INIT-1:0] dbl;
        logic [NUM_INIT-1:0]   res;
        int                    start;
        dbl   = {req, req};
        res   = '0;
        start = 0;
        for (int i = 0; i < NUM_INIT; i++) begin
            if (last[i]) begin
                start = i + 1;
            end
        end
        for (int k = NUM_INIT; k > 0; k--) begin
            if (dbl[start + k - 1]) begin
                res = '0;
                res[(start + k - 1) % NUM_INIT] = 1'b1;
            end
        end
        return res;
    endfunction

    assign rr_pick  = pick_lrs(bus.req, last_q);
    assign dma_high = bus.dma_pri & bus.req[INIT_DMA];
    assign cpu_high = bus.cpu_pri & bus.in_isr & bus.req[INIT_CPU];

    always_comb begin
        grant_d = rr_pick;
        if (dma_high) begin
            grant_d = '0;
            grant_d[INIT_DMA] = 1'b1;
        end else if (cpu_high) begin
            grant_d = '0;
            grant_d[INIT_CPU] = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            grant_q <= '0;
            last_q  <= '0;
        end else begin
            grant_q <= grant_d;
            if (|grant_d) begin
                last_q <= grant_d;
            end
        end
    end

    assign bus.grant = grant_q;
endmodule

// ==== system_config_control.sv ====
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
module system_config_control (
    input  wire logic                            i_clk,
    input  wire logic                            i_rst,
    input  wire logic [sys_cfg_pkg::ADDR_W-1:0]  i_address,
    input  wire logic                            i_read,
    input  wire logic                            i_write,
    input  wire logic [sys_cfg_pkg::DATA_W-1:0]  i_writedata,
    input  wire logic [sys_cfg_pkg::BE_W-1:0]    i_byteenable,
    output logic      [sys_cfg_pkg::DATA_W-1:0]  o_readdata,
    output logic                                 o_waitrequest,
    input  wire logic                            i_sleep_active,
    output logic                                 o_usb_phy_clk_run,
    input  wire logic                            i_tmr23_tick,
    input  wire logic                            i_tmr_alt_tick,
    output logic                                 o_capture_tick,
    output logic                                 o_compare_tick,
    output logic                                 o_capture_alt_timebase,
    output logic                                 o_compare_alt_timebase,
    input  wire logic                            i_pps_wr,
    input  wire logic                            i_pmd_wr,
    input  wire logic                            i_pg_wr,
    output logic                                 o_pps_wr_ok,
    output logic                                 o_pmd_wr_ok,
    output logic                                 o_pg_wr_ok,
    output logic                                 o_pin_select_lock,
    output logic                                 o_module_disable_lock,
    output logic                                 o_permission_group_lock,
    input  wire logic [sys_cfg_pkg::NUM_INIT-1:0] i_sram_req,
    input  wire logic                            i_cpu_in_isr,
    output logic      [sys_cfg_pkg::NUM_INIT-1:0] o_sram_grant,
    output logic                                 o_dma_sram_priority,
    output logic                                 o_cpu_irq_sram_priority,
    output logic                                 o_unlocked
);
    import sys_cfg_pkg::*;

    // expands byte enables to a bit mask
    function automatic logic [DATA_W-1:0] lane_mask(
        input logic [BE_W-1:0] be
    );
        logic [DATA_W-1:0] m;
        m = ZERO_WORD;
        for (int b = 0; b < BE_W; b++) begin
            m[b*8 +: 8] = {8{be[b]}};
        end
        return m;
    endfunction

    sys_cfg_if cfg_bus ();

    // bus handshake state
    logic                 wait_q;
    logic                 wait_d;
    logic [DATA_W-1:0]    rdata_q;
    logic [DATA_W-1:0]    rdata_d;

    // registers
    logic [DATA_W-1:0]    config_q;
    logic [DATA_W-1:0]    config_d;
    logic                 lock_wr_q;
    logic                 lock_wr_d;
    logic [NUM_GATE-1:0]  refused_q;
    logic [NUM_GATE-1:0]  refused_d;

    // decode
    logic                 req_seen;
    logic                 rd_commit;
    logic                 wr_commit;
    logic                 hit_config;
    logic                 hit_unlock;
    logic                 hit_status;
    logic [DATA_W-1:0]    be_mask;
    logic [DATA_W-1:0]    cfg_mask;
    logic                 cfg_write;
    logic                 cfg_refused;
    logic                 status_write;
    logic [DATA_W-1:0]    w1c_bits;
    logic [DATA_W-1:0]    status_word;
    logic [DATA_W-1:0]    read_mux;

    // write gates and timebase outputs
    logic [NUM_GATE-1:0]  gate_wr;
    logic [NUM_GATE-1:0]  gate_lock;
    logic [NUM_GATE-1:0]  gate_ok_q;
    logic [NUM_GATE-1:0]  gate_refuse;
    logic [NUM_GATE-1:0]  gate_clear;
    logic                 cap_tick_q;
    logic                 cmp_tick_q;
    logic                 usb_run_q;

    // bus decode
    assign req_seen   = (i_read | i_write) & wait_q;
    assign rd_commit  = i_read & ~wait_q;
    assign wr_commit  = i_write & ~wait_q;
    assign hit_config = (i_address == OFS_CONFIG);
    assign hit_unlock = (i_address == OFS_UNLOCK);
    assign hit_status = (i_address == OFS_STATUS);
    assign be_mask    = lane_mask(i_byteenable);
    assign cfg_mask   = be_mask & CONFIG_IMPL;

    assign cfg_write   = wr_commit & hit_config & cfg_bus.unlocked;
    assign cfg_refused = wr_commit & hit_config & ~cfg_bus.unlocked;
    assign status_write = wr_commit & hit_status;
    assign w1c_bits    = status_write ? (i_writedata & be_mask & STATUS_W1C)
                                      : ZERO_WORD;

    // key writes feed the unlock sequencer
    assign cfg_bus.key_wr   = wr_commit & hit_unlock;
    assign cfg_bus.key_data = i_writedata & be_mask;

    // status word
    always_comb begin
        status_word = ZERO_WORD;
        status_word[ST_UNLOCKED] = cfg_bus.unlocked;
        status_word[ST_LOCK_WR]  = lock_wr_q;
        status_word[ST_GATE_LO +: NUM_GATE] = refused_q;
    end

    // read selection, unmapped offsets and the key register read zero
    assign read_mux = hit_config ? (config_q & CONFIG_IMPL) :
                      hit_status ? status_word : ZERO_WORD;

    // one wait cycle, then a single low cycle that completes the access
    always_comb begin
        wait_d  = 1'b1;
        rdata_d = rdata_q;
        if (req_seen) begin
            wait_d  = 1'b0;
            rdata_d = i_read ? read_mux : ZERO_WORD;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_q  <= 1'b1;
            rdata_q <= ZERO_WORD;
        end else begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // configuration register update
    always_comb begin
        config_d = config_q;
        if (cfg_write) begin
            config_d = (config_q & ~cfg_mask)
                     | (i_writedata & cfg_mask);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            config_q <= CONFIG_RESET;
        end else begin
            config_q <= config_d;
        end
    end

    // sticky status, a new event wins over a clear in the same cycle
    always_comb begin
        lock_wr_d = lock_wr_q;
        if (w1c_bits[ST_LOCK_WR]) begin
            lock_wr_d = 1'b0;
        end
        if (cfg_refused) begin
            lock_wr_d = 1'b1;
        end
    end

    assign gate_clear = w1c_bits[ST_GATE_LO +: NUM_GATE];
    assign refused_d  = (refused_q & ~gate_clear) | gate_refuse;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lock_wr_q <= 1'b0;
            refused_q <= '0;
        end else begin
            lock_wr_q <= lock_wr_d;
            refused_q <= refused_d;
        end
    end

    // write gates for the pin-select, module-disable and permission groups
    assign gate_wr[GATE_PPS]   = i_pps_wr;
    assign gate_wr[GATE_PMD]   = i_pmd_wr;
    assign gate_wr[GATE_PG]    = i_pg_wr;
    assign gate_lock[GATE_PPS] = config_q[BIT_PPS_LOCK];
    assign gate_lock[GATE_PMD] = config_q[BIT_PMD_LOCK];
    assign gate_lock[GATE_PG]  = config_q[BIT_PG_LOCK];

    genvar g;
    generate
        for (g = 0; g < NUM_GATE; g++) begin : gen_gate
            assign gate_refuse[g] = gate_wr[g] & gate_lock[g];
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    gate_ok_q[g] <= 1'b0;
                end else begin
                    gate_ok_q[g] <= gate_wr[g] & ~gate_lock[g];
                end
            end
        end
    endgenerate

    // timebase selection and usb phy clock control
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cap_tick_q <= 1'b0;
            cmp_tick_q <= 1'b0;
            usb_run_q  <= 1'b1;
        end else begin
            cap_tick_q <= config_q[BIT_ICA] ? i_tmr_alt_tick
                                            : i_tmr23_tick;
            cmp_tick_q <= config_q[BIT_OCA] ? i_tmr_alt_tick
                                            : i_tmr23_tick;
            usb_run_q  <= ~(config_q[BIT_USB_SSEN] & i_sleep_active);
        end
    end

    // sram arbitration
    assign cfg_bus.dma_pri = config_q[BIT_DMA_PRI];
    assign cfg_bus.cpu_pri = config_q[BIT_CPU_PRI];
    assign cfg_bus.in_isr  = i_cpu_in_isr;
    assign cfg_bus.req     = i_sram_req;

    sram_prio_arbiter u_arbiter (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .bus   (cfg_bus.arb)
    );

    sys_cfg_unlock u_unlock (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .bus   (cfg_bus.unlock)
    );

    // outputs
    assign o_readdata              = rdata_q;
    assign o_waitrequest           = wait_q;
    assign o_usb_phy_clk_run       = usb_run_q;
    assign o_capture_tick          = cap_tick_q;
    assign o_compare_tick          = cmp_tick_q;
    assign o_capture_alt_timebase  = config_q[BIT_ICA];
    assign o_compare_alt_timebase  = config_q[BIT_OCA];
    assign o_pps_wr_ok             = gate_ok_q[GATE_PPS];
    assign o_pmd_wr_ok             = gate_ok_q[GATE_PMD];
    assign o_pg_wr_ok              = gate_ok_q[GATE_PG];
    assign o_pin_select_lock       = config_q[BIT_PPS_LOCK];
    assign o_module_disable_lock   = config_q[BIT_PMD_LOCK];
    assign o_permission_group_lock = config_q[BIT_PG_LOCK];
    assign o_sram_grant            = cfg_bus.grant;
    assign o_dma_sram_priority     = config_q[BIT_DMA_PRI];
    assign o_cpu_irq_sram_priority = config_q[BIT_CPU_PRI];
    assign o_unlocked              = cfg_bus.unlocked;

endmodule

// ==== system_config_control_chk.sv ====
`timescale 1ns/1ns
module system_config_control_chk (
    input wire logic                               i_clk,
    input wire logic                               i_rst,
    input wire logic                               i_sleep_active,
    input wire logic                               o_usb_phy_clk_run,
    input wire logic                               i_tmr23_tick,
    input wire logic                               i_tmr_alt_tick,
    input wire logic                               o_capture_tick,
    input wire logic                               o_compare_tick,
    input wire logic                               o_capture_alt_timebase,
    input wire logic                               o_compare_alt_timebase,
    input wire logic                               i_pps_wr,
    input wire logic                               i_pmd_wr,
    input wire logic                               i_pg_wr,
    input wire logic                               o_pps_wr_ok,
    input wire logic                               o_pmd_wr_ok,
    input wire logic                               o_pg_wr_ok,
    input wire logic                               o_pin_select_lock,
    input wire logic                               o_module_disable_lock,
    input wire logic                               o_permission_group_lock,
    input wire logic [sys_cfg_pkg::NUM_INIT-1:0]   i_sram_req,
    input wire logic                               i_cpu_in_isr,
    input wire logic [sys_cfg_pkg::NUM_INIT-1:0]   o_sram_grant,
    input wire logic                               o_dma_sram_priority,
    input wire logic                               o_cpu_irq_sram_priority,
    input wire logic                               o_unlocked
);
    import sys_cfg_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    AST_PIN_GATE: assert property (!$past(i_rst) |->
        o_pps_wr_ok == ($past(i_pps_wr) && !$past(o_pin_select_lock)))
        else $error("pin select gate wrong");
    AST_MOD_GATE: assert property (!$past(i_rst) |->
        o_pmd_wr_ok == ($past(i_pmd_wr) && !$past(o_module_disable_lock)))
        else $error("module disable gate wrong");
    AST_GRP_GATE: assert property (!$past(i_rst) |->
        o_pg_wr_ok == ($past(i_pg_wr) && !$past(o_permission_group_lock)))
        else $error("permission group gate wrong");
    AST_USB_AWAKE: assert property (
        !$past(i_rst) && !$past(i_sleep_active) |-> o_usb_phy_clk_run)
        else $error("phy clock stopped while awake");
    AST_CAP_TICK: assert property (!$past(i_rst) |-> o_capture_tick ==
        ($past(o_capture_alt_timebase) ? $past(i_tmr_alt_tick)
                                       : $past(i_tmr23_tick)))
        else $error("capture tick from wrong pair");
    AST_CMP_TICK: assert property (!$past(i_rst) |-> o_compare_tick ==
        ($past(o_compare_alt_timebase) ? $past(i_tmr_alt_tick)
                                       : $past(i_tmr23_tick)))
        else $error("compare tick from wrong pair");
    AST_GRANT_LEGAL: assert property (!$past(i_rst) |->
        $onehot0(o_sram_grant) && ((o_sram_grant & ~$past(i_sram_req)) == 0))
        else $error("grant not one-hot or not requested");
    AST_DMA_WINS: assert property (!$past(i_rst) &&
        $past(i_sram_req[0]) && $past(o_dma_sram_priority)
        |-> o_sram_grant == 3'h1)
        else $error("dma priority not honoured");
    AST_CPU_WINS: assert property (!$past(i_rst) &&
        $past(i_sram_req[1]) && $past(o_cpu_irq_sram_priority) &&
        $past(i_cpu_in_isr) &&
        !($past(i_sram_req[0]) && $past(o_dma_sram_priority))
        |-> o_sram_grant == 3'h2)
        else $error("cpu interrupt priority not honoured");
    AST_PROTECT: assert property ($changed({o_dma_sram_priority,
        o_cpu_irq_sram_priority, o_capture_alt_timebase,
        o_compare_alt_timebase, o_pin_select_lock, o_module_disable_lock,
        o_permission_group_lock}) |-> $past(o_unlocked))
        else $error("protected bit changed while locked");
endmodule

bind system_config_control system_config_control_chk chk_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_sleep_active(i_sleep_active),
    .o_usb_phy_clk_run(o_usb_phy_clk_run), .i_tmr23_tick(i_tmr23_tick),
    .i_tmr_alt_tick(i_tmr_alt_tick), .o_capture_tick(o_capture_tick),
    .o_compare_tick(o_compare_tick),
    .o_capture_alt_timebase(o_capture_alt_timebase),
    .o_compare_alt_timebase(o_compare_alt_timebase),
    .i_pps_wr(i_pps_wr), .i_pmd_wr(i_pmd_wr), .i_pg_wr(i_pg_wr),
    .o_pps_wr_ok(o_pps_wr_ok), .o_pmd_wr_ok(o_pmd_wr_ok),
    .o_pg_wr_ok(o_pg_wr_ok), .o_pin_select_lock(o_pin_select_lock),
    .o_module_disable_lock(o_module_disable_lock),
    .o_permission_group_lock(o_permission_group_lock),
    .i_sram_req(i_sram_req), .i_cpu_in_isr(i_cpu_in_isr),
    .o_sram_grant(o_sram_grant), .o_dma_sram_priority(o_dma_sram_priority),
    .o_cpu_irq_sram_priority(o_cpu_irq_sram_priority),
    .o_unlocked(o_unlocked)
);

// ==== system_config_control_tb.sv ====
`timescale 1ns/1ns
module system_config_control_tb;
    import sys_cfg_pkg::*;
    logic              i_clk, i_rst, i_read, i_write, i_sleep_active;
    logic              i_tmr23_tick, i_tmr_alt_tick, i_cpu_in_isr;
    logic              o_waitrequest, o_usb_phy_clk_run, o_unlocked;
    logic              o_capture_tick, o_compare_tick;
    logic [ADDR_W-1:0] i_address;
    logic [DATA_W-1:0] i_writedata, o_readdata;
    logic [BE_W-1:0]   i_byteenable;
    logic [2:0]        gate_wr, gate_ok, i_sram_req, o_sram_grant, seen;
    logic [6:0]        lv;
    int                fail_count, checks, cyc;

    system_config_control dut_u (
        .i_clk(i_clk), .i_rst(i_rst), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .i_byteenable(i_byteenable), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .i_sleep_active(i_sleep_active),
        .o_usb_phy_clk_run(o_usb_phy_clk_run), .i_tmr23_tick(i_tmr23_tick),
        .i_tmr_alt_tick(i_tmr_alt_tick), .o_capture_tick(o_capture_tick),
        .o_compare_tick(o_compare_tick), .o_capture_alt_timebase(lv[4]),
        .o_compare_alt_timebase(lv[3]), .i_pps_wr(gate_wr[0]),
        .i_pmd_wr(gate_wr[1]), .i_pg_wr(gate_wr[2]),
        .o_pps_wr_ok(gate_ok[0]), .o_pmd_wr_ok(gate_ok[1]),
        .o_pg_wr_ok(gate_ok[2]), .o_pin_select_lock(lv[2]),
        .o_module_disable_lock(lv[1]), .o_permission_group_lock(lv[0]),
        .i_sram_req(i_sram_req), .i_cpu_in_isr(i_cpu_in_isr),
        .o_sram_grant(o_sram_grant), .o_dma_sram_priority(lv[6]),
        .o_cpu_irq_sram_priority(lv[5]), .o_unlocked(o_unlocked)
    );

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            $display("mismatch at %0t: run timed out", $time);
            tally_and_finish();
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: word %h not %h", $time, got, exp);
        end
    endtask

    task automatic chk_flags(input logic [6:0] got, input logic [6:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: flags %b not %b", $time, got, exp);
        end
    endtask

    // one avalon access, held until waitrequest is seen low
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge i_clk);
        i_address <= a;
        i_write <= w;
        i_read <= !w;
        i_writedata <= d;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            fail_count++;
            $display("mismatch at %0t: no bus answer", $time);
        end
        q = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
        @(negedge i_clk);
    endtask

    task automatic rd32(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, ZERO_WORD, q);
        chk_word(q, exp);
    endtask

    task automatic gate(input int idx, input logic pass);
        @(posedge i_clk);
        gate_wr[idx] <= 1'b1;
        @(posedge i_clk);
        gate_wr <= 3'h0;
        @(negedge i_clk);
        chk_flags(7'(gate_ok), pass ? 7'(3'h1 << idx) : 7'h00);
    endtask

    task automatic tick(input logic t23, input logic talt, input logic [1:0] e);
        @(posedge i_clk);
        i_tmr23_tick <= t23;
        i_tmr_alt_tick <= talt;
        @(posedge i_clk);
        @(negedge i_clk);
        chk_flags(7'({o_capture_tick, o_compare_tick}), 7'(e));
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge i_clk);
        @(negedge i_clk);
    endtask

    initial begin
        {i_rst, i_read, i_write, i_sleep_active, i_cpu_in_isr} = 5'b10000;
        {i_tmr23_tick, i_tmr_alt_tick, gate_wr, i_sram_req} = 8'h00;
        i_address = 8'h00;
        i_writedata = ZERO_WORD;
        i_byteenable = 4'hF;
        fail_count = 0;
        checks = 0;
        cyc = 0;
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        rd32(OFS_CONFIG, ZERO_WORD);
        chk_flags({lv[6:1], o_usb_phy_clk_run}, 7'h01);
        wr32(OFS_CONFIG, 32'hFFFF_FFFF);
        rd32(OFS_CONFIG, ZERO_WORD);
        rd32(OFS_STATUS, 32'h0000_0002);
        wr32(OFS_UNLOCK, UNLOCK_KEY1);
        wr32(OFS_UNLOCK, UNLOCK_KEY2);
        chk_flags(7'(o_unlocked), 7'h01);
        wr32(OFS_CONFIG, 32'hFFFF_FFFF);
        rd32(OFS_CONFIG, CONFIG_IMPL);
        chk_flags(lv, 7'h7F);
        rd32(8'hFC, ZERO_WORD);
        for (int i = 0; i < 3; i++) gate(i, 1'b0);
        rd32(OFS_STATUS, 32'h0000_0073);
        wr32(OFS_STATUS, STATUS_W1C);
        rd32(OFS_STATUS, 32'h0000_0001);
        wr32(OFS_CONFIG, 32'h0303_0100);
        chk_flags(lv, 7'h78);
        for (int i = 0; i < 3; i++) gate(i, 1'b1);
        tick(1'b0, 1'b1, 2'b11);
        tick(1'b1, 1'b0, 2'b00);
        wr32(OFS_CONFIG, 32'h0001_0100);
        tick(1'b1, 1'b0, 2'b10);
        tick(1'b0, 1'b1, 2'b01);
        @(posedge i_clk);
        i_sleep_active <= 1'b1;
        wait_cycles(2);
        chk_flags(7'(o_usb_phy_clk_run), 7'h00);
        wr32(OFS_CONFIG, ZERO_WORD);
        wait_cycles(2);
        chk_flags(7'(o_usb_phy_clk_run), 7'h01);
        @(posedge i_clk);
        i_sram_req <= 3'h7;
        i_cpu_in_isr <= 1'b1;
        wr32(OFS_CONFIG, 32'h0300_0000);
        wait_cycles(2);
        chk_flags(7'(o_sram_grant), 7'h01);
        wr32(OFS_CONFIG, 32'h0100_0000);
        wait_cycles(2);
        chk_flags(7'(o_sram_grant), 7'h02);
        @(posedge i_clk);
        i_cpu_in_isr <= 1'b0;
        wait_cycles(2);
        seen = 3'h0;
        repeat (3) begin
            seen = seen | o_sram_grant;
            wait_cycles(0);
        end
        chk_flags(7'(seen), 7'h07);
        wr32(OFS_UNLOCK, ZERO_WORD);
        chk_flags(7'(o_unlocked), 7'h00);
        wr32(OFS_CONFIG, 32'hFFFF_FFFF);
        rd32(OFS_CONFIG, 32'h0100_0000);
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rd32(OFS_CONFIG, ZERO_WORD);
        chk_flags({lv[6:1], o_unlocked}, 7'h00);
        tally_and_finish();
    end
endmodule
